// ===== pkg/gpt_pkg.sv
// gpt_pkg: register map, control layout, codes and reset values of the
// 32-bit general purpose timer.
// assumes a 32-bit byte-addressed register port and one core clock.
package gpt_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] GPT_ADDR_RELOAD   = 32'hffff0320;
  localparam logic [31:0] GPT_ADDR_CURRENT  = 32'hffff0324;
  localparam logic [31:0] GPT_ADDR_CONTROL  = 32'hffff0328;
  localparam logic [31:0] GPT_ADDR_CLEAR    = 32'hffff032c;
  localparam logic [31:0] GPT_ADDR_CAPTURE  = 32'hffff0330;
  localparam logic [31:0] GPT_ADDR_STATUS   = 32'hffff0334;
  localparam logic [31:0] GPT_ADDR_INT_EN   = 32'hffff0338;
  localparam logic [31:0] GPT_ADDR_STAT_CLR = 32'hffff033c;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] GPT_RST_RELOAD  = 32'h00000000;
  localparam logic [31:0] GPT_RST_COUNT   = 32'hffffffff;
  localparam logic [31:0] GPT_RST_CONTROL = 32'h01000000;
  localparam logic [31:0] GPT_RST_CAPTURE = 32'h00000000;
  localparam logic [7:0]  GPT_RST_POST    = 8'h01;

  // ----------------------------------------------------------------
  // control register layout, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] post;
    logic       post_en;
    logic [2:0] rsvd;
    logic       post_flag;
    logic       post_src;
    logic       cap_en;
    logic [4:0] event_sel;
    logic [2:0] clk_sel;
    logic       up;
    logic       enable;
    logic       periodic;
    logic [1:0] format;
    logic [3:0] prescale;
  } gpt_ctrl_t;

  // register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gpt_bus_req_t;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  GPT_CLK_CORE   = 3'h0;
  localparam logic [2:0]  GPT_CLK_LPOSC  = 3'h1;
  localparam logic [2:0]  GPT_CLK_PIN_A  = 3'h2;
  localparam logic [2:0]  GPT_CLK_PIN_B  = 3'h3;
  localparam logic [3:0]  GPT_PRE_DIV16  = 4'h4;
  localparam logic [3:0]  GPT_PRE_DIV256 = 4'h8;
  localparam logic [3:0]  GPT_PRE_DIV32K = 4'hf;
  localparam logic [14:0] GPT_TERM_DIV1  = 15'h0000;
  localparam logic [14:0] GPT_TERM_DIV16 = 15'h000f;
  localparam logic [14:0] GPT_TERM_D256  = 15'h00ff;
  localparam logic [14:0] GPT_TERM_D32K  = 15'h7fff;
  localparam logic [1:0]  GPT_FMT_BIN    = 2'h0;
  localparam logic [1:0]  GPT_FMT_HMS24  = 2'h2;
  localparam logic [1:0]  GPT_FMT_HMS256 = 2'h3;

  // clock-style field limits: hundredths, seconds, minutes, hours
  localparam logic [7:0]  GPT_LIM_HUND   = 8'h63;
  localparam logic [7:0]  GPT_LIM_SECMIN = 8'h3b;
  localparam logic [7:0]  GPT_LIM_HR24   = 8'h17;
  localparam logic [7:0]  GPT_LIM_HR256  = 8'hff;

  // status / enable / clear bit positions
  localparam int          GPT_ST_TIMER   = 0;
  localparam int          GPT_ST_CAPTURE = 1;

endpackage

// ===== test/gpt_timer_tb.sv
// gpt_timer_tb: self-checking bench for the 32-bit general purpose timer.
// assumes the register port, status and enable map of gpt_pkg.
`timescale 1ns/10ps
`default_nettype none
module gpt_timer_tb;
  import gpt_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic         clock = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  gpt_bus_req_t bus_req = '0;
  logic [31:0]  bus_rdata;
  logic         lp_osc_clk = 1'b0;
  logic         pin_gpio_a = 1'b0;
  logic         pin_gpio_b = 1'b0;
  logic         low_power = 1'b0;
  logic [31:0]  irq_sources = '0;
  logic         irq;
  int           mismatches = 0;
  int           n_compared = 0;
  localparam logic [31:0] EN = 32'h00000080, UP = 32'h00000100, PER = 32'h00000040;
  localparam logic [31:0] PA = {20'h0, GPT_CLK_PIN_A, 9'h0};
  always #12.5 clock = ~clock;
  gpt_timer DUT (
    .clock       (clock),
    .rst         (rst),
    .clk_en      (clk_en),
    .bus_req     (bus_req),
    .bus_rdata   (bus_rdata),
    .lp_osc_clk  (lp_osc_clk),
    .pin_gpio_a  (pin_gpio_a),
    .pin_gpio_b  (pin_gpio_b),
    .low_power   (low_power),
    .irq_sources (irq_sources),
    .irq         (irq)
  );
  // ----------------------------------------------------------------
  // bus, source and compare tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  task automatic chk_word(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] got;
    rd(a, got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    @(posedge clock);
    #1;
    n_compared++;
    if (irq !== exp) begin
      mismatches++;
      $display("Error at %0t: irq %h expected %h", $time, irq, exp);
    end
  endtask
  // rising edges on one source; slow against the core clock so each is synced
  task automatic pulse(input logic [2:0] sel, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      case (sel)
        GPT_CLK_LPOSC: lp_osc_clk <= 1'b1;
        GPT_CLK_PIN_B: pin_gpio_b <= 1'b1;
        default:       pin_gpio_a <= 1'b1;
      endcase
      repeat (4) @(posedge clock);
      lp_osc_clk <= 1'b0;
      pin_gpio_a <= 1'b0;
      pin_gpio_b <= 1'b0;
    end
    repeat (8) @(posedge clock);
  endtask
  // reload, control, then clear write to load the counter and drop timer status
  task automatic arm(input logic [31:0] ld, input logic [31:0] ctrl);
    wr(GPT_ADDR_RELOAD, ld);
    wr(GPT_ADDR_CONTROL, ctrl);
    wr(GPT_ADDR_CLEAR, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_word(GPT_ADDR_RELOAD, 32'h00000000);
    chk_word(GPT_ADDR_CURRENT, 32'hffffffff);
    chk_word(GPT_ADDR_CONTROL, 32'h01000000);
    chk_word(GPT_ADDR_CAPTURE, 32'h00000000);
    chk_word(GPT_ADDR_STATUS, 32'h00000000);
    chk_word(GPT_ADDR_INT_EN, 32'h00000000);
    chk_irq(1'b0);
    $display("reset values done");
  endtask
  task automatic t_access;
    @(posedge clock);
    clk_en <= 1'b0;
    wr(GPT_ADDR_RELOAD, 32'h12345678);
    clk_en <= 1'b1;
    chk_word(GPT_ADDR_RELOAD, 32'h00000000);
    wr(GPT_ADDR_RELOAD, 32'hcafe0001);
    chk_word(GPT_ADDR_RELOAD, 32'hcafe0001);
    wr(GPT_ADDR_CURRENT, 32'h0);
    wr(GPT_ADDR_CAPTURE, 32'h5);
    chk_word(GPT_ADDR_CURRENT, 32'hffffffff);
    chk_word(GPT_ADDR_CAPTURE, 32'h00000000);
    wr(32'hffff0340, 32'hffffffff);
    chk_word(32'hffff0340, 32'h00000000);
    wr(GPT_ADDR_CLEAR, 32'h0);
    chk_word(GPT_ADDR_CURRENT, 32'hcafe0001);
    $display("register access done");
  endtask
  task automatic t_sources;
    logic [2:0] sels [3] = '{GPT_CLK_LPOSC, GPT_CLK_PIN_A, GPT_CLK_PIN_B};
    @(posedge clock);
    low_power <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      arm(32'h00000100, EN | UP | {20'h0, sels[i], 9'h0});
      pulse(sels[i], 4);
      chk_word(GPT_ADDR_CURRENT, 32'h00000104);
    end
    arm(32'h00000100, EN | UP);
    repeat (20) @(posedge clock);
    chk_word(GPT_ADDR_CURRENT, 32'h00000100);
    low_power <= 1'b0;
    wr(GPT_ADDR_CONTROL, 32'h0);
    $display("clock sources done");
  endtask
  task automatic t_prescale;
    arm(32'h00000010, EN | UP | PA | GPT_PRE_DIV16);
    pulse(GPT_CLK_PIN_A, 32);
    chk_word(GPT_ADDR_CURRENT, 32'h00000012);
    arm(32'h00000010, EN | UP | PA | GPT_PRE_DIV256);
    pulse(GPT_CLK_PIN_A, 256);
    chk_word(GPT_ADDR_CURRENT, 32'h00000011);
    $display("prescaler done");
  endtask
  task automatic t_wrap;
    logic [31:0] ld  [7] = '{32'h5, 32'h5, 32'hffffffff, 32'h173b3b63,
                             32'h173b3b63, 32'h01000000, 32'h0};
    logic [31:0] ct  [7] = '{0, PER, UP, UP | 32'h20, UP | 32'h30, 32'h20, 0};
    int          n   [7] = '{6, 6, 1, 1, 1, 1, 1};
    logic [31:0] exv [7] = '{32'hffffffff, 32'h5, 32'h0, 32'h0,
                             32'h18000000, 32'h003b3b63, 32'hffffffff};
    logic [31:0] st  [7] = '{1, 1, 1, 1, 0, 0, 1};
    wr(GPT_ADDR_INT_EN, 32'h1);
    for (int i = 0; i < 7; i++) begin
      arm(ld[i], EN | PA | ct[i]);
      pulse(GPT_CLK_PIN_A, n[i]);
      chk_word(GPT_ADDR_CURRENT, exv[i]);
      chk_word(GPT_ADDR_STATUS, st[i]);
    end
    chk_irq(1'b1);
    wr(GPT_ADDR_RELOAD, 32'h00000077);
    wr(GPT_ADDR_CLEAR, 32'hdeadbeef);
    chk_irq(1'b0);
    chk_word(GPT_ADDR_CURRENT, 32'h00000077);
    $display("wrap and format done");
  endtask
  task automatic t_post;
    logic [31:0] c;
    c = EN | UP | PER | PA | 32'h00040000 | 32'h03000000;
    arm(32'hfffffffe, c);
    pulse(GPT_CLK_PIN_A, 4);
    chk_word(GPT_ADDR_STATUS, 32'h0);
    chk_word(GPT_ADDR_CONTROL, (c & 32'h00ffffff) | 32'h02000000);
    pulse(GPT_CLK_PIN_A, 2);
    chk_word(GPT_ADDR_STATUS, 32'h1);
    chk_word(GPT_ADDR_CONTROL, (c & 32'h00ffffff) | 32'h00080000);
    c = c & 32'h00ffffff;
    arm(32'hfffffffe, c);
    pulse(GPT_CLK_PIN_A, 2);
    chk_word(GPT_ADDR_STATUS, 32'h1);
    wr(GPT_ADDR_CONTROL, 32'h0);
    $display("post-scaler done");
  endtask
  task automatic t_capture;
    arm(32'h00000040, EN | UP | PA | 32'h00020000 | 32'h00005000);
    wr(GPT_ADDR_INT_EN, 32'h2);
    pulse(GPT_CLK_PIN_A, 3);
    irq_sources[5] <= 1'b1;
    repeat (3) @(posedge clock);
    chk_word(GPT_ADDR_CAPTURE, 32'h00000043);
    chk_irq(1'b1);
    pulse(GPT_CLK_PIN_A, 2);
    chk_word(GPT_ADDR_CAPTURE, 32'h00000043);
    chk_word(GPT_ADDR_CURRENT, 32'h00000045);
    wr(GPT_ADDR_INT_EN, 32'h0);
    chk_irq(1'b0);
    wr(GPT_ADDR_INT_EN, 32'h2);
    chk_irq(1'b1);
    wr(GPT_ADDR_STAT_CLR, 32'h2);
    chk_irq(1'b0);
    chk_word(GPT_ADDR_STATUS, 32'h0);
    irq_sources <= '0;
    $display("capture and interrupt done");
  endtask
  // ----------------------------------------------------------------
  // verdict and sequence
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_access();
    t_sources();
    t_prescale();
    t_wrap();
    t_post();
    t_capture();
    print_verdict();
  end
  // the long prescaler case dominates the run; some nineteen times its length is ample
  initial begin
    #(25 * 40000);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/gpt_step.sv
// gpt_step: next counter value and wrap flag for one count step,
// binary or hours:minutes:seconds:hundredths.
// assumes each clock-style field is one byte, hours in the top byte.
`timescale 1ns/10ps
`default_nettype none
module gpt_step (
  // current value and mode
  input  wire logic [31:0] cur,
  input  wire logic        up,
  input  wire logic [1:0]  format,
  // result
  output logic      [31:0] next_val,
  output logic             wrap
);
  import gpt_pkg::*;

  logic [7:0] lim [4];
  logic [4:0] carry;
  logic [31:0] hms_val;

  assign lim[0] = GPT_LIM_HUND;
  assign lim[1] = GPT_LIM_SECMIN;
  assign lim[2] = GPT_LIM_SECMIN;
  assign lim[3] = (format == GPT_FMT_HMS24) ? GPT_LIM_HR24 : GPT_LIM_HR256;
  assign carry[0] = 1'b1;

  // ripple carry/borrow through the four clock fields
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_field
      logic [7:0] f;
      assign f = cur[8*i +: 8];
      assign carry[i+1] = carry[i] & (up ? (f >= lim[i]) : (f == 8'h00));
      assign hms_val[8*i +: 8] = !carry[i] ? f :
                                 up ? ((f >= lim[i]) ? 8'h00 : 8'(f + 8'h01)) :
                                      ((f == 8'h00) ? lim[i] : 8'(f - 8'h01));
    end
  endgenerate

  always_comb begin
    if (format == GPT_FMT_BIN) begin
      next_val = up ? 32'(cur + 32'h1) : 32'(cur - 32'h1);
      wrap     = up ? (cur == 32'hffffffff) : (cur == 32'h00000000);
    end else begin
      next_val = hms_val;
      wrap     = carry[4];
    end
  end

endmodule
`default_nettype wire

// ===== verilog/gpt_timer.sv
// gpt_timer: 32-bit up/down timer with prescaler, clock-style format,
// event capture, post-scaler, reload and a level interrupt.
// assumes pins and the low-power oscillator are asynchronous and slow
// against the core clock; irq sources are on the core clock.
`timescale 1ns/10ps
`default_nettype none

module gpt_timer (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // register port
  input  wire gpt_pkg::gpt_bus_req_t bus_req,
  output logic                [31:0] bus_rdata,
  // asynchronous clock sources
  input  wire logic                  lp_osc_clk,
  input  wire logic                  pin_gpio_a,
  input  wire logic                  pin_gpio_b,
  // chip state and events
  input  wire logic                  low_power,
  input  wire logic           [31:0] irq_sources,
  // interrupt
  output logic                       irq
);
  import gpt_pkg::*;

  typedef struct packed {
    logic [31:0] reload;
    logic [31:0] cnt;
    gpt_ctrl_t   ctrl;
    logic [31:0] cap;
    logic [7:0]  post_cnt;
    logic [1:0]  status;
    logic [1:0]  int_en;
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        src_prev;
    logic [31:0] irq_prev;
    logic [14:0] presc;
    logic [31:0] rdata;
  } gpt_state_t;

  // all ones count out of reset
  localparam gpt_state_t GPT_RST_STATE = '{
    reload:   GPT_RST_RELOAD,
    cnt:      GPT_RST_COUNT,
    ctrl:     GPT_RST_CONTROL,
    cap:      GPT_RST_CAPTURE,
    post_cnt: GPT_RST_POST, // control reads 0x01000000 out of reset
    status:   2'h0,
    int_en:   2'h0,
    sync1:    3'h0,
    sync2:    3'h0,
    src_prev: 1'b0,
    irq_prev: 32'h00000000,
    presc:    15'h0000,
    rdata:    32'h00000000
  };

  gpt_state_t  q;
  gpt_state_t  n;

  logic        wr_reload;
  logic        wr_control;
  logic        wr_clear;
  logic        wr_int_en;
  logic        wr_stat_clr;
  logic        src_level;
  logic        src_tick;
  logic [14:0] term;
  logic        pre_tick;
  logic [31:0] step_val;
  logic        step_wrap;
  logic        timeout;
  logic [7:0]  post_target;
  logic        post_match;
  logic        timer_event;
  logic        cap_hit;
  gpt_ctrl_t   ctrl_wr;
  gpt_ctrl_t   ctrl_rd;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_reload   = bus_req.wr && (bus_req.addr == GPT_ADDR_RELOAD);
  assign wr_control  = bus_req.wr && (bus_req.addr == GPT_ADDR_CONTROL);
  assign wr_clear    = bus_req.wr && (bus_req.addr == GPT_ADDR_CLEAR);
  assign wr_int_en   = bus_req.wr && (bus_req.addr == GPT_ADDR_INT_EN);
  assign wr_stat_clr = bus_req.wr && (bus_req.addr == GPT_ADDR_STAT_CLR);
  assign ctrl_wr     = gpt_ctrl_t'(bus_req.wdata);

  // ----------------------------------------------------------------
  // source select and prescaler
  // ----------------------------------------------------------------
  // sync2 bits: [0] lp osc, [1] pin a, [2] pin b
  always_comb begin
    unique case (q.ctrl.clk_sel)
      GPT_CLK_LPOSC: src_level = q.sync2[0];
      GPT_CLK_PIN_A: src_level = q.sync2[1];
      GPT_CLK_PIN_B: src_level = q.sync2[2];
      default:       src_level = 1'b0;
    endcase
  end

  // core clock stops in low power, the other sources do not
  assign src_tick = (q.ctrl.clk_sel == GPT_CLK_CORE) ? !low_power
                                                     : (src_level && !q.src_prev);

  always_comb begin
    unique case (q.ctrl.prescale)
      GPT_PRE_DIV16:  term = GPT_TERM_DIV16;
      GPT_PRE_DIV256: term = GPT_TERM_D256;
      GPT_PRE_DIV32K: term = GPT_TERM_D32K;
      default:        term = GPT_TERM_DIV1;
    endcase
  end

  assign pre_tick = q.ctrl.enable && src_tick && (q.presc >= term);

  // ----------------------------------------------------------------
  // count step, post-scaler, capture
  // ----------------------------------------------------------------
  gpt_step u_step (
    .cur      (q.cnt),
    .up       (q.ctrl.up),
    .format   (q.ctrl.format),
    .next_val (step_val),
    .wrap     (step_wrap)
  );

  assign timeout     = pre_tick && step_wrap;
  assign post_target = (q.ctrl.post == 8'h00) ? 8'h01 : q.ctrl.post;
  // bit 18 routes the interrupt through the post-scaler
  assign post_match  = timeout && q.ctrl.post_src && (8'(q.post_cnt + 8'h01) == post_target);
  assign timer_event = q.ctrl.post_src ? post_match : timeout;
  // each rising edge of the chosen source captures; a held level does not
  assign cap_hit     = q.ctrl.cap_en && irq_sources[q.ctrl.event_sel] && !q.irq_prev[q.ctrl.event_sel];

  always_comb begin
    ctrl_rd           = q.ctrl;
    ctrl_rd.post      = q.post_cnt;
    ctrl_rd.rsvd      = 3'h0;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n          = q;
    n.sync1    = {pin_gpio_b, pin_gpio_a, lp_osc_clk};
    n.sync2    = q.sync1;
    n.src_prev = src_level;
    n.irq_prev = irq_sources;
    n.rdata    = 32'h00000000;

    if (!q.ctrl.enable) begin
      n.presc = 15'h0000;
    end else if (src_tick) begin
      n.presc = (q.presc >= term) ? 15'h0000 : 15'(q.presc + 15'h0001);
    end

    // clear write reloads at once, else periodic reloads on wrap
    if (wr_clear) begin
      n.cnt = q.reload;
    end else if (pre_tick) begin
      n.cnt = (step_wrap && q.ctrl.periodic) ? q.reload : step_val;
    end

    if (cap_hit) begin
      n.cap = q.cnt;
    end

    if (timeout && q.ctrl.post_src) begin
      n.post_cnt = post_match ? 8'h00 : 8'(q.post_cnt + 8'h01);
    end

    if (wr_reload) begin
      n.reload = bus_req.wdata;
    end
    if (wr_control) begin
      n.ctrl           = ctrl_wr;
      n.ctrl.rsvd      = 3'h0;
      n.ctrl.post_flag = q.ctrl.post_flag;
      n.post_cnt       = 8'h00;
    end
    if (wr_int_en) begin
      n.int_en = bus_req.wdata[1:0];
    end

    // clears first so that a same-cycle event wins
    if (wr_clear) begin
      n.status[GPT_ST_TIMER] = 1'b0;
      n.ctrl.post_flag       = 1'b0;
    end
    if (wr_stat_clr) begin
      n.status = q.status & ~bus_req.wdata[1:0];
    end
    if (post_match) begin
      n.ctrl.post_flag = 1'b1;
    end
    if (timer_event) begin
      n.status[GPT_ST_TIMER] = 1'b1;
    end
    if (cap_hit) begin
      n.status[GPT_ST_CAPTURE] = 1'b1;
    end

    if (bus_req.rd) begin
      unique case (bus_req.addr)
        GPT_ADDR_RELOAD:  n.rdata = q.reload;
        GPT_ADDR_CURRENT: n.rdata = q.cnt;
        GPT_ADDR_CONTROL: n.rdata = ctrl_rd;
        GPT_ADDR_CAPTURE: n.rdata = q.cap;
        GPT_ADDR_STATUS:  n.rdata = {30'h0, q.status};
        GPT_ADDR_INT_EN:  n.rdata = {30'h0, q.int_en};
        default:          n.rdata = 32'h00000000;
      endcase
    end
  end

  // clk_en low freezes everything, synchronisers included
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= GPT_RST_STATE;
    end else if (clk_en) begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus_rdata = q.rdata;
  assign irq       = |(q.status & q.int_en);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_clear_reload;
    clk_en && wr_clear |=> q.cnt == $past(q.reload);
  endproperty
  a_clear_reload: assert property (p_clear_reload) else $error("clear write did not reload");

  property p_clear_irq;
    clk_en && wr_clear && !timer_event |=> !q.status[GPT_ST_TIMER];
  endproperty
  a_clear_irq: assert property (p_clear_irq) else $error("timer interrupt not cleared");

  property p_capture;
    clk_en && cap_hit |=> q.cap == $past(q.cnt) && q.status[GPT_ST_CAPTURE];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_hold_disabled;
    clk_en && !q.ctrl.enable && !wr_clear |=> $stable(q.cnt);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("disabled timer moved");

  property p_up_count;
    clk_en && pre_tick && q.ctrl.up && q.ctrl.format == GPT_FMT_BIN && !step_wrap && !wr_clear
      |=> q.cnt == $past(q.cnt) + 32'h1;
  endproperty
  a_up_count: assert property (p_up_count) else $error("up count step wrong");

  property p_post_flag;
    clk_en && post_match |=> q.ctrl.post_flag && q.post_cnt == 8'h00;
  endproperty
  a_post_flag: assert property (p_post_flag) else $error("compare flag not set");

  property p_post_irq;
    clk_en && post_match |=> q.status[GPT_ST_TIMER];
  endproperty
  a_post_irq: assert property (p_post_irq) else $error("post-scaler interrupt missing");

  property p_zero_post;
    clk_en && wr_control && bus_req.wdata[31:24] == 8'h00 |=> post_target == 8'h01;
  endproperty
  a_zero_post: assert property (p_zero_post) else $error("zero post field not one");

  property p_div16;
    pre_tick && q.ctrl.prescale == GPT_PRE_DIV16 |-> q.presc == 15'h000f;
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 tick early");

  property p_free_wrap;
    clk_en && pre_tick && step_wrap && !q.ctrl.periodic && !wr_clear |=> q.cnt == $past(step_val);
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free-running did not wrap");

  c_capture:  cover property (clk_en && cap_hit);
  c_post:     cover property (clk_en && post_match);
  c_periodic: cover property (clk_en && timeout && q.ctrl.periodic);
  c_irq:      cover property (irq ##1 clk_en && wr_clear);

endmodule
`default_nettype wire
